// [src/mbpt_pkg.sv]
// Constants shared by the match based pwm timer and its prescaler.
// Assumes a single clock domain and plain control ports, no register bus.
package mbpt_pkg;
    localparam int          TIMER_W     = 32;
    localparam int          NUM_MATCH   = 7;
    localparam int          NUM_PWM     = 6;
    localparam int          ACT_W       = 3;
    localparam int          ACT_IRQ     = 0;
    localparam int          ACT_RST     = 1;
    localparam int          ACT_STOP    = 2;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_STEP  = 32'h0000_0001;
endpackage : mbpt_pkg

// [src/mbpt_prescaler.sv]
// Programmable prescaler that paces the timer/counter.
// Assumes enable and clear come from the timer core in the same clock domain.
`timescale 1ns/10ps
module mbpt_prescaler #(
    parameter int W = mbpt_pkg::TIMER_W
) (
    // Clock, reset and enable.
    input  wire logic     sys_clk_in,
    input  wire logic     rst_n_in,
    input  wire logic     clk_en_in,
    // Link to the timer core.
    mbpt_tick_if.presc    tk
);
    import mbpt_pkg::*;

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    wire          wrap_hit = (count_r == tk.limit);

    // The tick fires once limit plus one cycles have passed, then restarts.
    assign tk.tick  = tk.enable && !tk.clear && wrap_hit;
    assign tk.count = count_r;

    assign count_nxt = tk.clear  ? W'(COUNT_RESET) :
                       !tk.enable ? count_r :
                       wrap_hit  ? W'(COUNT_RESET) :
                                   W'(count_r + W'(COUNT_STEP));

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            count_r <= W'(COUNT_RESET);
        else if (clk_en_in)
            count_r <= count_nxt;
    end

    AST_TICK_RESTART: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        tk.tick && clk_en_in |=> count_r == W'(COUNT_RESET))
        else $error("prescaler did not restart after tick");

    AST_TICK_AT_LIMIT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        tk.tick |-> count_r == tk.limit && tk.enable)
        else $error("tick without reaching the prescale limit");
endmodule : mbpt_prescaler

// [src/mbpt_tick_if.sv]
// Carrier between the timer core and its prescaler.
// Assumes both ends share the one system clock.
`timescale 1ns/10ps
interface mbpt_tick_if #(
    parameter int W = mbpt_pkg::TIMER_W
);
    logic         enable;
    logic         clear;
    logic [W-1:0] limit;
    logic         tick;
    logic [W-1:0] count;

    modport ctrl  (output enable, output clear, output limit, input tick, input count);
    modport presc (input enable, input clear, input limit, output tick, output count);
endinterface : mbpt_tick_if

// [src/mbpt_top.sv]
// Match based pwm timer: 32-bit timer/counter, prescaler, seven match
// registers with staged updates and six pwm outputs.
// Assumes all control inputs are synchronous to sys_clk_in.
// Contract
// - Cycle-rate match resets the count to zero, setting the pwm period.
// - Single-edge outputs rise at the cycle-rate match that starts each cycle.
// - One extra match per single-edge output sets its fall; period is shared.
// - A single-edge output programmed constant low never rises.
// - Double-edge outputs rise and fall on two matches; order sets polarity.
// - Each double-edge output uses two matches; edges go anywhere in cycle.
// - Seven matches give six single, three double, or mixed outputs.
// - Each match may continue, stop or reset the timer, optionally signalling.
// - In pwm mode, new match values apply only at cycle start, after software releases them.
// - Period and width are any count; all outputs share one repetition rate.
// - Without pwm mode the block is a plain match timer, outputs low.
// - A 32-bit prescaler feeds a 32-bit timer/counter from the clock.
`timescale 1ns/10ps
module mbpt_top #(
    parameter int TW = mbpt_pkg::TIMER_W
) (
    // Clock, reset and enable.
    input  wire logic                                        sys_clk_in,
    input  wire logic                                        rst_n_in,
    input  wire logic                                        clk_en_in,
    // Timer control.
    input  wire logic                                        timer_en_in,
    input  wire logic                                        counter_reset_in,
    input  wire logic                                        pwm_mode_in,
    input  wire logic [TW-1:0]                               prescale_in,
    // Match setup.
    input  wire logic [mbpt_pkg::NUM_MATCH*TW-1:0]           match_value_in,
    input  wire logic [mbpt_pkg::NUM_MATCH*mbpt_pkg::ACT_W-1:0] match_action_in,
    input  wire logic [mbpt_pkg::NUM_MATCH-1:0]              release_in,
    // Output setup.
    input  wire logic [mbpt_pkg::NUM_PWM:1]                  pwm_enable_in,
    input  wire logic [mbpt_pkg::NUM_PWM:2]                  double_edge_in,
    // Pins and status.
    output logic      [mbpt_pkg::NUM_PWM:1]                  pwm_out,
    output logic      [mbpt_pkg::NUM_MATCH-1:0]              match_irq_out,
    output logic      [TW-1:0]                               timer_count_out,
    output logic      [TW-1:0]                               prescale_count_out,
    output logic      [mbpt_pkg::NUM_MATCH-1:0]              release_pending_out,
    output logic                                             timer_stopped_out
);
    import mbpt_pkg::*;

    function automatic logic act_bit(
        input logic [NUM_MATCH*ACT_W-1:0] acts,
        input int                         idx,
        input int                         pos
    );
        act_bit = acts[idx*ACT_W+pos];
    endfunction : act_bit

    mbpt_tick_if #(.W(TW)) tk ();

    mbpt_prescaler #(.W(TW)) u_presc (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .clk_en_in  (clk_en_in),
        .tk         (tk)
    );

    logic [TW-1:0]        tc_r;
    logic [TW-1:0]        tc_nxt;
    logic                 stopped_r;
    logic                 stopped_nxt;
    logic [TW-1:0]        active_r [NUM_MATCH];
    logic [TW-1:0]        staged_r [NUM_MATCH];
    logic [NUM_MATCH-1:0] pending_r;
    logic [NUM_MATCH-1:0] pending_nxt;
    logic [NUM_MATCH-1:0] irq_r;
    logic [NUM_PWM:1]     pwm_r;
    logic [NUM_PWM:1]     pwm_nxt;
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] evt;
    logic [NUM_MATCH-1:0] rst_act;
    logic [NUM_MATCH-1:0] stop_act;
    logic [NUM_MATCH-1:0] irq_act;

    wire run       = timer_en_in && !stopped_r;
    wire tick      = tk.tick;
    wire any_reset = |(evt & rst_act);
    wire cycle_evt = evt[0] && rst_act[0];
    wire apply_now = pwm_mode_in ? cycle_evt : 1'b1;

    assign tk.enable = run;
    assign tk.clear  = counter_reset_in;
    assign tk.limit  = prescale_in;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_MATCH; gi++)
        begin : g_match
            // Match zero always resets in pwm mode so the period is fixed by it.
            assign rst_act[gi]  = act_bit(match_action_in, gi, ACT_RST) ||
                                  (gi == 0 && pwm_mode_in);
            assign stop_act[gi] = act_bit(match_action_in, gi, ACT_STOP);
            assign irq_act[gi]  = act_bit(match_action_in, gi, ACT_IRQ);
            assign hit[gi]      = (tc_r == active_r[gi]);
            assign evt[gi]      = tick && hit[gi];
            // A release in the same cycle as an apply keeps the pending flag set.
            assign pending_nxt[gi] = release_in[gi] ||
                                     (pending_r[gi] && !apply_now);

            always_ff @(posedge sys_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    active_r[gi] <= TW'(COUNT_RESET);
                    staged_r[gi] <= TW'(COUNT_RESET);
                end
                else if (clk_en_in)
                begin
                    if (release_in[gi])
                        staged_r[gi] <= match_value_in[gi*TW +: TW];
                    if (pending_r[gi] && apply_now)
                        active_r[gi] <= staged_r[gi];
                end
            end

            AST_APPLY_AT_CYCLE: assert property (@(posedge sys_clk_in)
                disable iff (!rst_n_in)
                pwm_mode_in && $past(pwm_mode_in) && (active_r[gi] != $past(active_r[gi]))
                |-> $past(cycle_evt) && $past(pending_r[gi]))
                else $error("match value changed outside cycle start");
        end

        for (gi = 1; gi <= NUM_PWM; gi++)
        begin : g_pwm
            logic set_e;
            logic dbl;
            if (gi >= 2)
            begin : g_dbl
                assign dbl = double_edge_in[gi];
            end
            else
            begin : g_sgl
                assign dbl = 1'b0;
            end
            // Double edge rises on the previous match; single edge on match zero.
            assign set_e = dbl ? evt[gi-1] : evt[0];
            // Fall wins over rise, so a single-edge fall equal to the period is constant low.
            assign pwm_nxt[gi] = (!pwm_mode_in || !pwm_enable_in[gi]) ? 1'b0 :
                                 evt[gi] ? 1'b0 :
                                 set_e   ? 1'b1 : pwm_r[gi];

            AST_SINGLE_RISE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
                clk_en_in && pwm_mode_in && pwm_enable_in[gi] && !dbl && evt[0] && !evt[gi]
                |=> pwm_out[gi])
                else $error("single edge output did not rise at cycle start");

            AST_FALL_EDGE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
                clk_en_in && evt[gi] |=> !pwm_out[gi])
                else $error("output did not fall on its match");

            AST_CONST_LOW: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
                clk_en_in && !pwm_out[gi] && evt[0] && evt[gi] |=> !pwm_out[gi])
                else $error("constant low output rose");

            if (gi >= 2)
            begin : g_dbl_chk
                AST_DOUBLE_RISE: assert property (@(posedge sys_clk_in)
                    disable iff (!rst_n_in)
                    clk_en_in && pwm_mode_in && pwm_enable_in[gi] && dbl &&
                    evt[gi-1] && !evt[gi] |=> pwm_out[gi])
                    else $error("double edge output did not rise");
            end
        end
    endgenerate

    assign tc_nxt = counter_reset_in ? TW'(COUNT_RESET) :
                    !tick            ? tc_r :
                    any_reset        ? TW'(COUNT_RESET) :
                                       TW'(tc_r + TW'(COUNT_STEP));
    assign stopped_nxt = !counter_reset_in && (stopped_r || |(evt & stop_act));

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tc_r      <= TW'(COUNT_RESET);
            stopped_r <= 1'b0;
            pending_r <= '0;
            irq_r     <= '0;
            pwm_r     <= '0;
        end
        else if (clk_en_in)
        begin
            tc_r      <= tc_nxt;
            stopped_r <= stopped_nxt;
            pending_r <= pending_nxt;
            irq_r     <= evt & irq_act;
            pwm_r     <= pwm_nxt;
        end
    end

    assign pwm_out             = pwm_r;
    assign match_irq_out       = irq_r;
    assign timer_count_out     = tc_r;
    assign prescale_count_out  = tk.count;
    assign release_pending_out = pending_r;
    assign timer_stopped_out   = stopped_r;

    AST_PERIOD_RESET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && pwm_mode_in && evt[0] |=> timer_count_out == TW'(COUNT_RESET))
        else $error("count not reset at cycle rate match");

    AST_COUNT_STEP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && tick && !any_reset && !counter_reset_in
        |=> timer_count_out == TW'($past(tc_r) + TW'(COUNT_STEP)))
        else $error("timer did not advance by one on tick");

    AST_STOP_HOLDS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && |(evt & stop_act) && !counter_reset_in
        |=> timer_stopped_out ##1 ($past(counter_reset_in) || $stable(timer_count_out)))
        else $error("stop on match did not halt the timer");

    AST_TIMER_MODE_LOW: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && !pwm_mode_in |=> pwm_out == '0)
        else $error("pwm output driven outside pwm mode");

    AST_IRQ_PULSE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && evt[0] && irq_act[0] |=> match_irq_out[0])
        else $error("match interrupt pulse missing");
endmodule : mbpt_top

// [test/mbpt_load_model.sv]
// Load on the pwm pins: tallies high cycles of every output over each pwm cycle.
// Assumes output 1 rises once per cycle, which marks the start of a cycle.
`timescale 1ns/10ps
module mbpt_load_model (
    // Clock and pins.
    input  wire logic       sys_clk_in,
    input  wire logic [6:1] pwm_in,
    // Tally of the cycle just ended.
    output logic            tally_valid_out,
    output logic [7:0]      tally_out [1:6]
);
    logic [7:0] acc_r [1:6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic       prev_r      = 1'b0;
    wire        start       = pwm_in[1] && !prev_r;

    always @(posedge sys_clk_in)
    begin
        prev_r          <= pwm_in[1];
        tally_valid_out <= start;
        for (int n = 1; n <= 6; n++)
        begin
            if (start)
            begin
                tally_out[n] <= acc_r[n];
                acc_r[n]     <= 8'(pwm_in[n]);
            end
            else
            begin
                acc_r[n] <= acc_r[n] + 8'(pwm_in[n]);
            end
        end
    end
endmodule : mbpt_load_model

// [test/testbench.sv]
// Self-checking bench for the match based pwm timer.
// Assumes the load model on the pins and a 10 MHz system clock.
`timescale 1ns/10ps
module testbench;
    import mbpt_pkg::*;
    typedef struct { logic [6:0] irq; int cnt; int gap; } mbpt_irq_exp_type;
    typedef struct { logic skip; logic [7:0] t [1:6]; } mbpt_tally_exp_type;
    logic               clk      = 1'b0;
    logic               rst_n    = 1'b0;
    logic               cnt_rst  = 1'b1;
    logic               ce       = 1'b1;
    logic               ten      = 1'b1;
    logic [31:0]        psc;
    logic [31:0]        pc;
    logic               pwm_mode = 1'b0;
    logic [31:0]        presc    = 32'h0;
    logic [223:0]       mval     = 224'h0;
    logic [20:0]        mact     = 21'h0;
    logic [6:0]         rel      = 7'h00;
    logic [6:1]         pwm_en   = 6'h3F;
    logic [6:2]         dbl      = 5'h00;
    logic [6:1]         pwm;
    logic [6:0]         irq;
    logic [6:0]         pend;
    logic [31:0]        cnt;
    logic [31:0]        c;
    logic               stopped;
    logic               tval;
    logic [7:0]         tally [1:6];
    int                 n_errors = 0;
    int                 n_checks = 0;
    int                 gap      = 0;
    int                 seed     = 64247;
    int                 per;
    int                 r;
    mbpt_irq_exp_type   iq [$];
    mbpt_tally_exp_type tq [$];
    mbpt_irq_exp_type   ie;
    mbpt_tally_exp_type te;

    mbpt_top dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(ce), .timer_en_in(ten),
        .counter_reset_in(cnt_rst), .pwm_mode_in(pwm_mode), .prescale_in(presc),
        .match_value_in(mval), .match_action_in(mact), .release_in(rel),
        .pwm_enable_in(pwm_en), .double_edge_in(dbl), .pwm_out(pwm),
        .match_irq_out(irq), .timer_count_out(cnt), .prescale_count_out(psc),
        .release_pending_out(pend), .timer_stopped_out(stopped));
    mbpt_load_model load (.sys_clk_in(clk), .pwm_in(pwm), .tally_valid_out(tval),
        .tally_out(tally));

    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : cmp_vec

    task automatic ld(input int i, input logic [31:0] v, input logic [2:0] a);
        mval[i*32+:32] = v;
        mact[i*3+:3] = a;
    endtask : ld

    task automatic rel_pulse(input logic [6:0] m);
        @(negedge clk);
        rel = m;
        @(negedge clk);
        rel = 7'h00;
        @(negedge clk);
    endtask : rel_pulse

    task automatic drain();
        while (iq.size() + tq.size() != 0)
            @(negedge clk);
    endtask : drain

    // One pwm cycle of the mixed layout with output 1 falling at match m1.
    task automatic push_period(input int m1, input logic first);
        mbpt_tally_exp_type e;
        int                 w [1:6];
        w = '{m1 + 1, 6 - m1, 5, 0, 5, 4};
        e.skip = first;
        for (int n = 1; n <= 6; n++)
            e.t[n] = 8'(w[n] * per);
        iq.push_back(mbpt_irq_exp_type'{7'h01, 0, first ? -1 : 10 * per});
        tq.push_back(e);
    endtask : push_period

    initial
    begin
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    always @(negedge clk)
    begin
        gap++;
        if (irq !== 7'h00)
        begin
            if (iq.size() == 0)
                cmp_vec(32'(irq), 32'h0, "stray match event");
            else
            begin
                ie = iq.pop_front();
                cmp_vec(32'(irq), 32'(ie.irq), "event bits");
                if (ie.cnt >= 0)
                    cmp_vec(cnt, 32'(ie.cnt), "count after event");
                if (ie.gap >= 0)
                    cmp_vec(32'(gap), 32'(ie.gap), "event spacing");
            end
            gap = 0;
        end
        if (tval === 1'b1)
        begin
            if (tq.size() == 0)
                cmp_vec(32'h1, 32'h0, "stray pwm cycle");
            else
            begin
                te = tq.pop_front();
                for (int n = 1; n <= 6; n++)
                    if (!te.skip)
                        cmp_vec(32'(tally[n]), 32'(te.t[n]), "high time");
            end
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        per = $unsigned($random(seed)) % 4;
        presc = 32'(per);
        per = per + 1;
        // Timer mode: match 3 continues with an event, match 0 resets.
        for (int i = 1; i < 7; i++)
            ld(i, 32'hFFFF_0000, 3'h0);
        ld(0, 32'h5, 3'h3);
        ld(3, 32'h2, 3'h1);
        rel_pulse(7'h7F);
        for (int k = 0; k < 3; k++)
        begin
            iq.push_back(mbpt_irq_exp_type'{7'h08, 3, k == 0 ? -1 : 3 * per});
            iq.push_back(mbpt_irq_exp_type'{7'h01, 0, 3 * per});
        end
        cnt_rst = 1'b0;
        drain();
        cnt_rst = 1'b1;
        cmp_vec(32'(pwm), 32'h0, "timer mode pins");
        ld(3, 32'h2, 3'h0);
        ld(0, 32'h14, 3'h2);
        ld(2, 32'h3, 3'h5);
        rel_pulse(7'h05);
        iq.push_back(mbpt_irq_exp_type'{7'h04, -1, -1});
        cnt_rst = 1'b0;
        // Freeze the count before the stop match by each of the two enables.
        repeat (2) @(negedge clk);
        ten = 1'b0;
        c = cnt;
        pc = psc;
        repeat (4) @(negedge clk);
        cmp_vec(cnt, c, "count with timer disabled");
        cmp_vec(psc, pc, "prescaler with timer disabled");
        ten = 1'b1;
        ce = 1'b0;
        repeat (4) @(negedge clk);
        cmp_vec(cnt, c, "count with clock disabled");
        cmp_vec(psc, pc, "prescaler with clock disabled");
        ce = 1'b1;
        drain();
        repeat (4) @(negedge clk);
        c = cnt;
        repeat (8) @(negedge clk);
        cmp_vec(cnt, c, "count after stop");
        cmp_vec(32'(stopped), 32'h1, "stopped flag");
        cmp_vec(psc, 32'h0, "prescaler after stop");
        cnt_rst = 1'b1;
        @(negedge clk);
        cmp_vec(32'(stopped), 32'h0, "stopped flag cleared");
        // Pwm mode with a mix of single and double edge outputs.
        ld(0, 32'h9, 3'h1);
        ld(1, 32'h2, 3'h0);
        ld(2, 32'h6, 3'h0);
        ld(3, 32'h1, 3'h0);
        ld(4, 32'h9, 3'h0);
        ld(5, 32'h4, 3'h0);
        ld(6, 32'h8, 3'h0);
        rel_pulse(7'h7F);
        pwm_mode = 1'b1;
        dbl = 5'h13;
        push_period(2, 1'b1);
        for (int k = 0; k < 3; k++)
            push_period(2, 1'b0);
        cnt_rst = 1'b0;
        drain();
        // A new fall position takes effect only from the next cycle start.
        r = 1 + $unsigned($random(seed)) % 5;
        ld(1, 32'(r), 3'h0);
        push_period(2, 1'b0);
        push_period(r, 1'b0);
        push_period(r, 1'b0);
        @(negedge clk);
        cmp_vec(32'(pend), 32'h0, "pending before release");
        rel_pulse(7'h02);
        cmp_vec(32'(pend), 32'h2, "pending after release");
        drain();
        cmp_vec(32'(pend), 32'h0, "pending after apply");
        report_and_stop();
    end
endmodule : testbench
